// [hw/baud_tick.sv]
// Baud rate divider: one-cycle tick every div_i+1 clocks.
// Assumes div_i is quasi-static; a change restarts at most one period.
`timescale 1ns/100ps
module baud_tick import uart_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Divisor and tick
  input wire logic [15:0] div_i,
  output logic tick_o
);
  logic [15:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
    end else if (cnt_r >= div_i) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  assign tick_o = (cnt_r >= div_i);
endmodule : baud_tick

// [hw/rx_fifo.sv]
// Receive FIFO memory with registered head word.
// Head is forwarded on a write into the slot about to be read.
`timescale 1ns/100ps
module rx_fifo import uart_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Write side
  input wire logic push_i,
  input wire rx_entry_t wdata_i,
  output logic full_o,
  // Read side
  input wire logic pop_i,
  output rx_entry_t q_o,
  output logic empty_o
);
  localparam int D = 1 << RXF_AW;
  rx_entry_t mem_r [D];
  logic [RXF_AW-1:0] wr_r;
  logic [RXF_AW-1:0] rd_r;
  logic [RXF_AW-1:0] rd_nxt;
  logic [RXF_AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full_o = (cnt_r == (RXF_AW+1)'(D));
  assign empty_o = (cnt_r == '0);
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;
  assign rd_nxt = do_pop ? rd_r + 1'b1 : rd_r;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_r[wr_r] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i | flush_i) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 1'b1;
      end
      rd_r <= rd_nxt;
      cnt_r <= cnt_r + (RXF_AW+1)'(do_push) - (RXF_AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else if (do_push && wr_r == rd_nxt) begin
      q_o <= wdata_i;
    end else begin
      q_o <= mem_r[rd_nxt];
    end
  end
endmodule : rx_fifo

// [hw/uart_core.sv]
// Serial transceiver: framing, break, status and Wishbone registers.
// Assumes rx line synchronous to clk_i; classic Wishbone master.
// What this block does
// - High-speed select: 4 ticks, else 16
// - Field picks 9N, 8O, 8E, 8N formats
// - Stop select bit 0: two or one
// - Break: start, twelve zeros, stop; self-clearing
// - Status bit 12 reads zero, ignores writes
// - Shift-empty only when shifter and buffer empty
// - Parity error follows FIFO head character
// - Framing error follows FIFO head character
// - Overrun sets; clearing it flushes receiver
`timescale 1ns/100ps
module uart_core import uart_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial lines and interrupt
  input wire logic serial_rx_line_i,
  output logic serial_tx_line_o,
  output logic irq_o
);
  function automatic logic [15:0] merge16(input logic [15:0] old);
    merge16 = {sel_i[1] ? dat_i[15:8] : old[15:8],
               sel_i[0] ? dat_i[7:0] : old[7:0]};
  endfunction : merge16

  logic ack_r, req, wr, rd;
  logic [3:0] mode_r;
  logic [15:0] sta_ctl_r, sta_rd, baud_div_r;
  logic send_break_req_r, rx_overrun_flag_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_ev;
  logic high_speed_baud_sel, stop_bits_sel, tx_enable_bit;
  logic [1:0] parity_data_sel;
  logic par_en, nine, tick;
  logic [3:0] tpb_m1, last_bit;

  assign high_speed_baud_sel = mode_r[MODE_HS];
  assign parity_data_sel = mode_r[MODE_PDS_LO +: 2];
  assign stop_bits_sel = mode_r[MODE_STOP];
  assign tx_enable_bit = sta_ctl_r[STA_TXEN];
  assign tpb_m1 = high_speed_baud_sel ? TPB_HS_M1 : TPB_STD_M1;
  assign nine = (parity_data_sel == PDS_9N);
  assign par_en = (parity_data_sel == PDS_8O) ||
                  (parity_data_sel == PDS_8E);
  assign last_bit = nine ? 4'h8 : 4'h7;

  baud_tick u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(baud_div_r),
    .tick_o(tick)
  );

  // Bus: writes and pops happen on the acknowledged edge only
  assign req = cyc_i & stb_i;
  assign wr = req & ack_r & we_i;
  assign rd = req & ack_r & ~we_i;
  assign ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Transmit buffer and shifter
  tx_state_t tx_st;
  logic [3:0] tx_tcnt_r, tx_bitn_r;
  logic [8:0] tx_buf_r, tx_sh_r;
  logic tx_full_r, tx_par_r, tx_stopn_r, tx_brk_frame_r, tx_end;
  logic tx_load, tx_done, brk_done, tx_shift_empty;

  assign tx_end = tick & (tx_tcnt_r == tpb_m1);
  assign tx_load = tx_enable_bit & (tx_st == TX_IDLE) & tx_full_r &
                   ~send_break_req_r;
  assign tx_done = tx_end & (tx_st == TX_STOP) &
                   ~(stop_bits_sel & ~tx_stopn_r & ~tx_brk_frame_r);
  assign brk_done = tx_done & tx_brk_frame_r;
  assign tx_shift_empty = ~tx_full_r & (tx_st == TX_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_full_r <= 1'b0;
      tx_buf_r <= 9'h000;
    end else if (!tx_enable_bit) begin
      tx_full_r <= 1'b0;
    end else if (wr && adr_i == OFS_TXD && !tx_full_r && sel_i[0]) begin
      tx_full_r <= 1'b1;
      tx_buf_r <= dat_i[8:0];
    end else if (tx_load) begin
      tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_enable_bit) begin
      tx_st <= TX_IDLE;
      tx_tcnt_r <= 4'h0;
      tx_bitn_r <= 4'h0;
      tx_sh_r <= 9'h000;
      tx_par_r <= 1'b0;
      tx_stopn_r <= 1'b0;
      tx_brk_frame_r <= 1'b0;
    end else begin
      if (tx_st == TX_IDLE) begin
        tx_tcnt_r <= 4'h0;
      end else if (tick) begin
        tx_tcnt_r <= (tx_tcnt_r == tpb_m1) ? 4'h0 : tx_tcnt_r + 4'h1;
      end
      case (tx_st)
        TX_IDLE: begin
          tx_bitn_r <= 4'h0;
          tx_stopn_r <= 1'b0;
          tx_brk_frame_r <= 1'b0;
          if (send_break_req_r) begin
            tx_st <= TX_BRK;
          end else if (tx_full_r) begin
            tx_st <= TX_START;
            tx_sh_r <= tx_buf_r;
            tx_par_r <= (parity_data_sel == PDS_8O) ? ~^tx_buf_r[7:0]
                                                     : ^tx_buf_r[7:0];
          end
        end
        TX_START: begin
          if (tx_end) begin
            tx_st <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            tx_sh_r <= {1'b0, tx_sh_r[8:1]};
            tx_bitn_r <= tx_bitn_r + 4'h1;
            if (tx_bitn_r == last_bit) begin
              tx_st <= par_en ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            tx_st <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_done) begin
            tx_st <= TX_IDLE;
          end else if (tx_end) begin
            tx_stopn_r <= 1'b1;
          end
        end
        TX_BRK: begin
          if (tx_end) begin
            tx_bitn_r <= tx_bitn_r + 4'h1;
            if (tx_bitn_r == BRK_LAST) begin
              tx_st <= TX_STOP;
              tx_brk_frame_r <= 1'b1;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_tx_line_o <= 1'b1;
    end else begin
      case (tx_st)
        TX_START: serial_tx_line_o <= 1'b0;
        TX_BRK: serial_tx_line_o <= 1'b0;
        TX_DATA: serial_tx_line_o <= tx_sh_r[0];
        TX_PAR: serial_tx_line_o <= tx_par_r;
        default: serial_tx_line_o <= 1'b1;
      endcase
    end
  end

  // Receiver
  rx_state_t rx_st;
  logic [3:0] rx_tcnt_r, rx_bitn_r;
  logic [8:0] rx_sh_r;
  logic rx_parity_error_flag_r, rx_end, rx_push, rx_full, rx_empty, rx_overrun_flag_clr;
  rx_entry_t rx_entry, rx_head;

  assign rx_end = tick & (rx_tcnt_r == tpb_m1);
  assign rx_push = (rx_st == RX_STOP) & rx_end;
  assign rx_entry.data = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  assign rx_entry.parity_error_flag = rx_parity_error_flag_r;
  assign rx_entry.framing_error_flag = ~serial_rx_line_i;
  assign rx_overrun_flag_clr = wr & (adr_i == OFS_STA) & sel_i[0] &
                    ~dat_i[STA_RX_OVERRUN_FLAG] & rx_overrun_flag_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_overrun_flag_clr) begin
      rx_st <= RX_IDLE;
      rx_tcnt_r <= 4'h0;
      rx_bitn_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_parity_error_flag_r <= 1'b0;
    end else begin
      if (tick) begin
        rx_tcnt_r <= (rx_tcnt_r == tpb_m1) ? 4'h0 : rx_tcnt_r + 4'h1;
      end
      case (rx_st)
        RX_IDLE: begin
          rx_tcnt_r <= 4'h0;
          rx_bitn_r <= 4'h0;
          rx_parity_error_flag_r <= 1'b0;
          // Hold off while overrun stands
          if (!serial_rx_line_i && !rx_overrun_flag_r) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_tcnt_r == {1'b0, tpb_m1[3:1]}) begin
            rx_tcnt_r <= 4'h0;
            rx_st <= serial_rx_line_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_sh_r <= {serial_rx_line_i, rx_sh_r[8:1]};
            rx_bitn_r <= rx_bitn_r + 4'h1;
            if (rx_bitn_r == last_bit) begin
              rx_st <= par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            rx_parity_error_flag_r <= serial_rx_line_i ^ ((parity_data_sel == PDS_8O) ?
                         ~^rx_sh_r[8:1] : ^rx_sh_r[8:1]);
            rx_st <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  rx_fifo u_rxf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(rx_overrun_flag_clr),
    .push_i(rx_push),
    .wdata_i(rx_entry),
    .full_o(rx_full),
    .pop_i(rd && adr_i == OFS_RXD),
    .q_o(rx_head),
    .empty_o(rx_empty)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_overrun_flag_r <= 1'b0;
    end else if (rx_push && rx_full) begin
      rx_overrun_flag_r <= 1'b1;
    end else if (rx_overrun_flag_clr) begin
      rx_overrun_flag_r <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_RST;
      sta_ctl_r <= STA_CTL_RST;
      baud_div_r <= BAUD_RST;
      irq_mask_r <= IRQ_RST;
    end else if (wr) begin
      case (adr_i)
        OFS_MODE: mode_r <= 4'(merge16({12'h000, mode_r}));
        OFS_STA: sta_ctl_r <= merge16(sta_ctl_r) & STA_CTL_MASK;
        OFS_BAUD: baud_div_r <= merge16(baud_div_r);
        OFS_IRQ_MASK: irq_mask_r <= sel_i[0] ? dat_i[IRQ_W-1:0]
                                             : irq_mask_r;
        default: ;
      endcase
    end
  end

  // Break request: a new request wins over the hardware clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !tx_enable_bit) begin
      send_break_req_r <= 1'b0;
    end else if (wr && adr_i == OFS_STA && sel_i[1]) begin
      send_break_req_r <= dat_i[STA_BRK];
    end else if (brk_done) begin
      send_break_req_r <= 1'b0;
    end
  end

  always_comb begin
    sta_rd = sta_ctl_r;
    sta_rd[STA_BRK] = send_break_req_r;
    sta_rd[STA_TXBF] = tx_full_r;
    sta_rd[STA_TX_SHIFT_EMPTY] = tx_shift_empty;
    sta_rd[STA_RX_IDLE_FLAG] = (rx_st == RX_IDLE);
    sta_rd[STA_PARITY_ERROR_FLAG] = rx_head.parity_error_flag & ~rx_empty;
    sta_rd[STA_FRAMING_ERROR_FLAG] = rx_head.framing_error_flag & ~rx_empty;
    sta_rd[STA_RX_OVERRUN_FLAG] = rx_overrun_flag_r;
    sta_rd[STA_RXDA] = ~rx_empty;
  end

  // Interrupts: events win over a write-one clear
  assign irq_ev[IRQ_RX] = rx_push & ~rx_full;
  assign irq_ev[IRQ_TXBUF] = tx_load;
  assign irq_ev[IRQ_TXDONE] = tx_done & ~tx_brk_frame_r;
  assign irq_ev[IRQ_OVR] = rx_push & rx_full;
  assign irq_ev[IRQ_BRK] = brk_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= IRQ_RST;
    end else if (wr && adr_i == OFS_IRQ_STAT && sel_i[0]) begin
      irq_stat_r <= (irq_stat_r & ~dat_i[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      case (adr_i)
        OFS_MODE: dat_o <= {28'h0000000, mode_r};
        OFS_STA: dat_o <= {16'h0000, sta_rd};
        OFS_RXD: dat_o <= {23'h000000, rx_head.data};
        OFS_BAUD: dat_o <= {16'h0000, baud_div_r};
        OFS_IRQ_STAT: dat_o <= {27'h0000000, irq_stat_r};
        OFS_IRQ_MASK: dat_o <= {27'h0000000, irq_mask_r};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence brk_bit_end_s;
    tx_st == TX_BRK && tx_end && tx_bitn_r == BRK_LAST;
  endsequence

  start_width_a: assert property ((tx_st == TX_START) && tx_end &&
    tx_enable_bit |=> tx_st == TX_DATA && !serial_tx_line_o)
    else $error("start bit length wrong");
  data_count_a: assert property ((tx_st == TX_DATA) && tx_end &&
    tx_enable_bit && tx_bitn_r == last_bit
    |=> tx_st == (par_en ? TX_PAR : TX_STOP))
    else $error("data bit count wrong");
  stop_two_a: assert property ((tx_st == TX_STOP) && tx_end &&
    tx_enable_bit && stop_bits_sel && !tx_stopn_r && !tx_brk_frame_r
    |=> tx_st == TX_STOP)
    else $error("second stop bit missing");
  break_seq_a: assert property (brk_bit_end_s and tx_enable_bit
    |=> tx_st == TX_STOP && tx_brk_frame_r)
    else $error("break length wrong");
  break_low_a: assert property ((tx_st == TX_BRK) |=>
    !serial_tx_line_o || !tx_enable_bit)
    else $error("break not low");
  bit12_zero_a: assert property (req && !ack_r && adr_i == OFS_STA
    |=> !dat_o[12])
    else $error("status bit 12 not zero");
  shift_empty_a: assert property (tx_load |-> !tx_shift_empty)
    else $error("shift empty during load");
  head_parity_error_flag_a: assert property (rx_push && rx_empty && !rx_full
    |=> sta_rd[STA_PARITY_ERROR_FLAG] == $past(rx_entry.parity_error_flag))
    else $error("parity flag not head");
  head_framing_error_flag_a: assert property (rx_push && rx_empty && !rx_full
    |=> sta_rd[STA_FRAMING_ERROR_FLAG] == $past(rx_entry.framing_error_flag))
    else $error("framing flag not head");
  overrun_a: assert property (rx_overrun_flag_clr && !(rx_push && rx_full)
    |=> rx_empty && rx_st == RX_IDLE && !rx_overrun_flag_r)
    else $error("overrun clear did not flush");
endmodule : uart_core

// [hw/uart_pkg.sv]
// Shared constants, types and register map of the serial transceiver.
// Assumes one 250 MHz clock and a 32-bit classic Wishbone register bus.
package uart_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STA = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_RXD = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // Mode register fields
  localparam int MODE_HS = 3;
  localparam int MODE_PDS_LO = 1;
  localparam int MODE_STOP = 0;
  localparam logic [3:0] MODE_RST = 4'h0;
  // Status/control fields
  localparam int STA_BRK = 11;
  localparam int STA_TXEN = 10;
  localparam int STA_TXBF = 9;
  localparam int STA_TX_SHIFT_EMPTY = 8;
  localparam int STA_RX_IDLE_FLAG = 4;
  localparam int STA_PARITY_ERROR_FLAG = 3;
  localparam int STA_FRAMING_ERROR_FLAG = 2;
  localparam int STA_RX_OVERRUN_FLAG = 1;
  localparam int STA_RXDA = 0;
  localparam logic [15:0] STA_CTL_MASK = 16'he4e0;
  localparam logic [15:0] STA_CTL_RST = 16'h0000;
  // Parity/data encodings
  localparam logic [1:0] PDS_9N = 2'h3;
  localparam logic [1:0] PDS_8O = 2'h2;
  localparam logic [1:0] PDS_8E = 2'h1;
  // Ticks per bit, minus one
  localparam logic [3:0] TPB_HS_M1 = 4'h3;
  localparam logic [3:0] TPB_STD_M1 = 4'hf;
  // Break: start bit plus twelve zero bits, last index
  localparam logic [3:0] BRK_LAST = 4'hc;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Interrupt status bits
  localparam int IRQ_W = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TXBUF = 1;
  localparam int IRQ_TXDONE = 2;
  localparam int IRQ_OVR = 3;
  localparam int IRQ_BRK = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  // Receive FIFO
  localparam int RXF_AW = 2;

  typedef struct packed {
    logic framing_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;
endpackage : uart_pkg

// [sim/serial_peer.sv]
// Remote serial peer: captures frames seen on the transmit line and
// drives frames onto the receive line. Assumes bit_clks_i clocks a bit.
`timescale 1ns/100ps
module serial_peer (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic serial_tx_line_i,
  output logic serial_rx_line_o,
  // Frame setup and capture
  input wire logic [7:0] bit_clks_i,
  input wire logic [4:0] len_i,
  output logic [15:0] frame_o,
  output logic [7:0] start_len_o,
  output int frames_o
);
  logic [15:0] bits;
  logic [7:0] slen;
  logic low;
  int k;

  initial begin
    serial_rx_line_o = 1'b1;
    frame_o = 16'hffff;
    start_len_o = 8'h00;
    frames_o = 0;
  end

  // Samples before the edge's updates land, so mid-bit is race free
  always begin
    @(negedge serial_tx_line_i);
    bits = 16'hffff;
    slen = 8'h00;
    low = 1'b1;
    for (k = 0; k < len_i * bit_clks_i; k++) begin
      @(posedge clk_i);
      if (low && serial_tx_line_i === 1'b0) slen++;
      else low = 1'b0;
      if (k % bit_clks_i == bit_clks_i / 2) begin
        bits[k / bit_clks_i] = serial_tx_line_i;
      end
    end
    frame_o = bits;
    start_len_o = slen;
    frames_o++;
  end

  // Frame bits given LSB first, already holding start and stops
  task automatic send(input logic [15:0] f, input int n);
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      serial_rx_line_o <= f[i];
      repeat (bit_clks_i) @(posedge clk_i);
    end
  endtask : send
endmodule : serial_peer

// [sim/uart_frame_format_and_status_tb.sv]
// Self-checking bench: Wishbone registers, framing in every mode,
// break, receive errors, overrun and interrupt. Needs serial_peer.
`timescale 1ns/100ps
module uart_frame_format_and_status_tb import uart_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic rx_line;
  logic tx_line;
  logic irq_o;
  logic [7:0] bit_clks = 8'h10;
  logic [4:0] len = 5'h0a;
  logic [15:0] frame;
  logic [7:0] start_len;
  int frames;
  int bad_count = 0;
  int compares = 0;
  int seed = 57;
  logic [15:0] q;

  always #2 clk_i = ~clk_i;

  uart_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .serial_rx_line_i(rx_line), .serial_tx_line_o(tx_line),
    .irq_o(irq_o));

  serial_peer peer (.clk_i(clk_i), .serial_tx_line_i(tx_line),
    .serial_rx_line_o(rx_line), .bit_clks_i(bit_clks), .len_i(len),
    .frame_o(frame), .start_len_o(start_len), .frames_o(frames));

  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Ack is sampled before the edge updates, as a registered master does
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    if (ack_o !== 1'b1) begin
      bad_count++;
      test_done();
    end
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    check(q & m, e);
  endtask : rd_chk

  task automatic irq_chk(input logic e);
    @(posedge clk_i);
    check({15'h0000, irq_o}, {15'h0000, e});
  endtask : irq_chk

  task automatic wait_frame(input int f0);
    int n;
    n = 0;
    while (frames == f0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (frames == f0) begin
      bad_count++;
      test_done();
    end
  endtask : wait_frame

  function automatic logic [15:0] fbits(input logic [8:0] d,
                                        input logic [1:0] pds);
    logic [15:0] v;
    v = 16'hffff;
    v[0] = 1'b0;
    for (int i = 0; i < ((pds == PDS_9N) ? 9 : 8); i++) v[1 + i] = d[i];
    if (pds == PDS_8E) v[9] = ^d[7:0];
    if (pds == PDS_8O) v[9] = ~^d[7:0];
    return v;
  endfunction : fbits

  function automatic logic [4:0] flen(input logic [1:0] pds,
                                      input logic s2);
    return 5'h0a + ((pds == 2'h0) ? 5'h00 : 5'h01) + (s2 ? 5'h01 : 5'h00);
  endfunction : flen

  initial begin : main
    logic [8:0] d;
    logic [8:0] e;
    logic [3:0] m;
    int f0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_MODE, 16'hffff, 16'h0000);
    rd_chk(OFS_IRQ_MASK, 16'hffff, 16'h0000);
    rd_chk(OFS_STA, 16'hffff, 16'h0110);
    rd_chk(8'h1c, 16'hffff, 16'h0000);
    wb(1'b1, OFS_STA, 16'h1400);
    rd_chk(OFS_STA, 16'h1000, 16'h0000);
    wb(1'b1, OFS_BAUD, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      d = 9'($random(seed));
      d[0] = i[0];
      bit_clks <= m[3] ? 8'h04 : 8'h10;
      len <= flen(m[2:1], m[0]);
      wb(1'b1, OFS_MODE, {12'h000, m});
      f0 = frames;
      wb(1'b1, OFS_TXD, {7'h00, d});
      rd_chk(OFS_STA, 16'h0100, 16'h0000);
      // Queued second character: an early start would land in the stops
      e = 9'($random(seed));
      wb(1'b1, OFS_TXD, {7'h00, e});
      wait_frame(f0);
      check(frame, fbits(d, m[2:1]));
      if (d[0]) check({8'h00, start_len}, {8'h00, bit_clks});
      rd_chk(OFS_STA, 16'h0100, 16'h0000);
      wait_frame(f0 + 1);
      check(frame, fbits(e, m[2:1]));
      rd_chk(OFS_STA, 16'h0100, 16'h0100);
      peer.send(fbits(d, m[2:1]), len);
      rd_chk(OFS_STA, 16'h000d, 16'h0001);
      rd_chk(OFS_RXD, 16'h01ff, (m[2:1] == PDS_9N) ? {7'h00, d} :
             {8'h00, d[7:0]});
    end
    irq_chk(1'b0);
    wb(1'b1, OFS_MODE, 16'h000a);
    bit_clks <= 8'h04;
    len <= 5'h0b;
    // Bad parity, then bad stop with idle gap, then a clean one
    peer.send(fbits(9'h0a5, PDS_8E) ^ 16'h0200, 11);
    peer.send(fbits(9'h03c, PDS_8E) & 16'hfbff, 11);
    peer.send(16'hffff, 2);
    peer.send(fbits(9'h0c3, PDS_8E), 11);
    rd_chk(OFS_STA, 16'h000c, 16'h0008);
    rd_chk(OFS_RXD, 16'h00ff, 16'h00a5);
    rd_chk(OFS_STA, 16'h000c, 16'h0004);
    rd_chk(OFS_RXD, 16'h00ff, 16'h003c);
    rd_chk(OFS_STA, 16'h000c, 16'h0000);
    rd_chk(OFS_RXD, 16'h00ff, 16'h00c3);
    wb(1'b1, OFS_IRQ_STAT, 16'h001f);
    wb(1'b1, OFS_IRQ_MASK, 16'h0008);
    for (int i = 0; i < 5; i++) begin
      peer.send(fbits(9'($random(seed)) & 9'h0ff, PDS_8E), 11);
    end
    irq_chk(1'b1);
    rd_chk(OFS_STA, 16'h0003, 16'h0003);
    wb(1'b1, OFS_IRQ_MASK, 16'h0000);
    irq_chk(1'b0);
    wb(1'b1, OFS_IRQ_MASK, 16'h0008);
    irq_chk(1'b1);
    wb(1'b1, OFS_STA, 16'h0400);
    rd_chk(OFS_STA, 16'h0003, 16'h0000);
    wb(1'b1, OFS_IRQ_STAT, 16'h0008);
    irq_chk(1'b0);
    peer.send(fbits(9'h05a, PDS_8E), 11);
    rd_chk(OFS_RXD, 16'h00ff, 16'h005a);
    wb(1'b1, OFS_MODE, 16'h0008);
    len <= 5'h0e;
    f0 = frames;
    wb(1'b1, OFS_STA, 16'h0c00);
    wait_frame(f0);
    check(frame, 16'he000);
    rd_chk(OFS_STA, 16'h0800, 16'h0000);
    rd_chk(OFS_IRQ_STAT, 16'h0010, 16'h0010);
    test_done();
  end
endmodule : uart_frame_format_and_status_tb
